// ==== design/twp_pkg.sv ====
// constants and carrier types of the two-wire serial port
package twp_pkg;
    // last bit index of a group, and group-boundary masks
    localparam logic [4:0] HALF_LAST = 5'h0f;
    localparam logic [4:0] WIDE_LAST = 5'h1f;
    localparam logic [2:0] BYTE_LAST = 3'h7;
    localparam logic [3:0] HWORD_LAST = 4'hf;
    // shutdown tail: a couple of baud clocks, counted in half-bit ticks
    localparam logic [3:0] TAIL_TICKS = 4'h4;
    localparam logic [7:0] BRG_RST = 8'h00;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    localparam logic [15:0] HALF_ZERO = 16'h0000;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_SHIFT = 3'b010,
        TX_GAP = 3'b100
    } twp_tx_state_t;

    typedef struct packed {
        logic port_enable;
        logic wide_group;
        logic clock_invert;
        logic phase_select;
        logic byte_gap_enable;
        logic halfword_gap_enable;
        logic master;
        logic [7:0] bit_rate_divisor;
        logic [7:0] gap_length;
    } twp_cfg_t;

    typedef struct packed {
        logic tx_holding_free;
        logic tx_all_empty;
        logic tx_overwrite;
        logic rx_holding_full;
        logic rx_overrun;
        logic command_detect;
    } twp_irq_t;
endpackage

// ==== design/twp_port.sv ====
// two-wire serial port: transmitter, receiver, command detect, on/off logic
// Contract
// - 32-bit transmit holding register; wide sends 32 bits, else lower 16.
// - free pulse when port enabled and each time holding register empties.
// - one write strobe with a swap flag: normal data, or command word with lines swapped.
// - holding register copied to shift register when shifter is empty and no gap is running.
// - empty pulse when holding and shift registers both become empty.
// - write to a still-full holding register raises overwrite pulse.
// - shift out on data pin, command words on swapped lines, 16 or 32 bits.
// - clock_invert and phase_select give two launch/sample edge combinations, set by their XOR.
// - standard bus use is invert 0, phase 1: launch rising, sample falling.
// - baud tick from divisor-preloaded generator; 250 kbps-14.75 Mbps bus.
// - baud clock shifts transmitter and drives clock pin when master.
// - transmit bit counter divides by 16 or 32 and makes load pulse.
// - gap after each 32-bit group; after bytes or halfwords when enabled.
// - receiver shifts data pin into 32-bit register on the far clock.
// - receive bit counter divides by 16 or 32 and makes the load pulse.
// - receive holding loaded after 16 or 32 bits; halfword uses lower 16.
// - receive-full pulse each time receive holding register is loaded.
// - overrun pulse when a word arrives while both buffer entries hold unread data.
// - on disable, run until transmitter empty plus tail; active flag reports.
// - detect swapped clock and data on bus inputs, raise command pulse.
// - groups are serialised most significant bit first.
`timescale 1ns/1ps
module twp_port
    import twp_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic srst_i,
    // configuration and status
    input wire twp_cfg_t cfg_i,
    output logic port_active_o,
    output twp_irq_t irq_o,
    // transmit holding register writes
    input wire logic tx_wr_i,
    input wire logic tx_swap_i,
    input wire logic [31:0] tx_data_i,
    // receive holding register stream
    output logic rx_valid_o,
    input wire logic rx_ready_i,
    output logic [31:0] rx_data_o,
    // bus pins
    input wire logic bus_clock_pin_i,
    output logic bus_clock_pin_o,
    output logic bus_clock_pin_oe_n_o,
    input wire logic bus_data_pin_i,
    output logic bus_data_pin_o,
    output logic bus_data_pin_oe_n_o
);
    twp_tx_state_t st_reg, st_next;
    logic [7:0] brg_reg;
    logic half_reg, act_reg, en_q_reg, empty_q_reg;
    logic [4:0] bcnt_reg;
    logic [8:0] gcnt_reg;
    logic [3:0] tail_reg;
    logic [31:0] thr_reg, tsr_reg;
    logic thr_full_reg, thr_swap_reg, tsr_v_reg, tsr_swap_reg;
    logic lvl_clk_reg, lvl_dat_reg;
    twp_irq_t irq_reg;

    // baud generator and transmitter control decode
    wire tick_w = (brg_reg == BRG_RST);
    wire is_idle_w = (st_reg == TX_IDLE);
    wire is_shift_w = (st_reg == TX_SHIFT);
    wire is_gap_w = (st_reg == TX_GAP);
    wire [4:0] last_idx_w = cfg_i.wide_group ? WIDE_LAST : HALF_LAST;
    wire last_w = (bcnt_reg == last_idx_w);
    wire bound_w = is_shift_w & tick_w & half_reg;
    wire end_w = bound_w & last_w;
    wire gap_w = (cfg_i.gap_length != BRG_RST)
        & ((cfg_i.byte_gap_enable & (bcnt_reg[2:0] == BYTE_LAST))
        | (cfg_i.halfword_gap_enable & (bcnt_reg[3:0] == HWORD_LAST))
        | (cfg_i.wide_group & last_w));
    wire gap_done_w = is_gap_w & tick_w & (gcnt_reg == 9'h001);
    wire need_w = is_idle_w | (end_w & !gap_w) | (gap_done_w & !tsr_v_reg);
    wire load_w = need_w & thr_full_reg;
    wire wr_ok_w = tx_wr_i & act_reg;
    wire empty_w = is_idle_w & !thr_full_reg & !tsr_v_reg;
    wire [31:0] load_word_w = cfg_i.wide_group ? thr_reg
        : {thr_reg[15:0], HALF_ZERO};
    wire drive_w = cfg_i.master & act_reg;

    always_comb begin
        st_next = st_reg;
        unique case (st_reg)
            TX_IDLE: begin
                if (load_w)
                    st_next = TX_SHIFT;
            end
            TX_SHIFT: begin
                if (bound_w & gap_w)
                    st_next = TX_GAP;
                else if (end_w & !load_w)
                    st_next = TX_IDLE;
            end
            TX_GAP: begin
                if (gap_done_w & (tsr_v_reg | load_w))
                    st_next = TX_SHIFT;
                else if (gap_done_w)
                    st_next = TX_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            st_reg <= TX_IDLE;
            brg_reg <= BRG_RST;
            half_reg <= 1'b0;
            bcnt_reg <= 5'h00;
            gcnt_reg <= 9'h000;
        end else begin
            st_reg <= st_next;
            brg_reg <= tick_w ? cfg_i.bit_rate_divisor
                : brg_reg - 8'h01;
            if (load_w)
                half_reg <= 1'b0;
            else if (is_shift_w & tick_w)
                half_reg <= !half_reg;
            if (load_w | end_w)
                bcnt_reg <= 5'h00;
            else if (bound_w)
                bcnt_reg <= bcnt_reg + 5'h01;
            if (bound_w)
                gcnt_reg <= {cfg_i.gap_length, 1'b0};
            else if (is_gap_w & tick_w)
                gcnt_reg <= gcnt_reg - 9'h001;
        end
    end

    // holding and shift registers
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            thr_reg <= WORD_RST;
            thr_full_reg <= 1'b0;
            thr_swap_reg <= 1'b0;
            tsr_reg <= WORD_RST;
            tsr_v_reg <= 1'b0;
            tsr_swap_reg <= 1'b0;
        end else begin
            if (wr_ok_w) begin
                thr_reg <= tx_data_i;
                thr_swap_reg <= tx_swap_i;
            end
            thr_full_reg <= wr_ok_w | (thr_full_reg & !load_w);
            if (load_w) begin
                tsr_reg <= load_word_w;
                tsr_swap_reg <= thr_swap_reg;
            end else if (bound_w)
                tsr_reg <= {tsr_reg[30:0], 1'b0};
            if (load_w)
                tsr_v_reg <= 1'b1;
            else if (end_w)
                tsr_v_reg <= 1'b0;
        end
    end

    // line levels: launch edge on first half, sample edge on second
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            lvl_clk_reg <= 1'b0;
            lvl_dat_reg <= 1'b0;
        end else if (is_shift_w & tick_w) begin
            lvl_clk_reg <= half_reg ? !cfg_i.phase_select
                : cfg_i.phase_select;
            if (!half_reg)
                lvl_dat_reg <= tsr_reg[31];
        end else if (!is_shift_w) begin
            lvl_clk_reg <= !cfg_i.phase_select;
            lvl_dat_reg <= 1'b0;
        end
    end

    // pins; swapped lines put the clock on the data pin for command words
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            bus_clock_pin_o <= 1'b0;
            bus_data_pin_o <= 1'b0;
            bus_clock_pin_oe_n_o <= 1'b1;
            bus_data_pin_oe_n_o <= 1'b1;
        end else begin
            bus_clock_pin_o <= tsr_swap_reg ? lvl_dat_reg
                : lvl_clk_reg ^ cfg_i.clock_invert;
            bus_data_pin_o <= tsr_swap_reg ? lvl_clk_reg ^ cfg_i.clock_invert
                : lvl_dat_reg;
            bus_clock_pin_oe_n_o <= !drive_w;
            bus_data_pin_oe_n_o <= !drive_w;
        end
    end

    // on/off logic: drains the transmitter before dropping the active flag
    wire tail_done_w = (tail_reg == TAIL_TICKS);
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            act_reg <= 1'b0;
            en_q_reg <= 1'b0;
            empty_q_reg <= 1'b1;
            tail_reg <= 4'h0;
        end else begin
            en_q_reg <= cfg_i.port_enable;
            empty_q_reg <= empty_w;
            if (cfg_i.port_enable | !empty_w)
                tail_reg <= 4'h0;
            else if (tick_w & !tail_done_w)
                tail_reg <= tail_reg + 4'h1;
            if (cfg_i.port_enable)
                act_reg <= 1'b1;
            else if (empty_w & tail_done_w)
                act_reg <= 1'b0;
        end
    end
    assign port_active_o = act_reg;

    // receiver: bus pins sampled by two flip-flops before any logic
    logic [2:0] rck_reg, rdt_reg;
    logic [31:0] rsr_reg;
    logic [4:0] rbit_reg;
    logic dflag_reg;
    wire rx_on_w = act_reg & !cfg_i.master;
    wire ck_edge_w = rck_reg[1] ^ rck_reg[2];
    wire samp_w = rx_on_w & ck_edge_w
        & (rck_reg[1] == !(cfg_i.phase_select ^ cfg_i.clock_invert));
    wire dat_rise_w = rdt_reg[1] & !rdt_reg[2];
    wire detect_w = rx_on_w & dat_rise_w & dflag_reg & !ck_edge_w;
    wire rx_last_w = (rbit_reg == last_idx_w);
    wire push_w = samp_w & rx_last_w & !detect_w;
    wire [31:0] rx_word_w = cfg_i.wide_group ? {rsr_reg[30:0], rdt_reg[1]}
        : {HALF_ZERO, rsr_reg[14:0], rdt_reg[1]};

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            rck_reg <= 3'h0;
            rdt_reg <= 3'h0;
            rsr_reg <= WORD_RST;
            rbit_reg <= 5'h00;
            dflag_reg <= 1'b0;
        end else begin
            rck_reg <= {rck_reg[1:0], bus_clock_pin_i};
            rdt_reg <= {rdt_reg[1:0], bus_data_pin_i};
            if (ck_edge_w)
                dflag_reg <= 1'b0;
            else if (dat_rise_w)
                dflag_reg <= 1'b1;
            if (detect_w | push_w | !rx_on_w)
                rbit_reg <= 5'h00;
            else if (samp_w) begin
                rbit_reg <= rbit_reg + 5'h01;
                rsr_reg <= {rsr_reg[30:0], rdt_reg[1]};
            end
        end
    end

    // two-entry receive buffer: output word plus one spare
    logic [31:0] spare_reg;
    logic spare_v_reg;
    wire pop_w = rx_valid_o & rx_ready_i;
    wire out_take_w = push_w & (!rx_valid_o | (pop_w & !spare_v_reg));
    wire spare_take_w = push_w & !out_take_w & (!spare_v_reg | pop_w);
    wire overrun_w = push_w & rx_valid_o & spare_v_reg & !pop_w;

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            rx_valid_o <= 1'b0;
            rx_data_o <= WORD_RST;
            spare_v_reg <= 1'b0;
            spare_reg <= WORD_RST;
        end else begin
            if (out_take_w)
                rx_data_o <= rx_word_w;
            else if (pop_w & spare_v_reg)
                rx_data_o <= spare_reg;
            rx_valid_o <= out_take_w | spare_v_reg | (rx_valid_o & !pop_w);
            if (spare_take_w)
                spare_reg <= rx_word_w;
            spare_v_reg <= spare_take_w | (spare_v_reg & !pop_w);
        end
    end

    // event pulses, one cycle each
    always_ff @(posedge ref_clk_i) begin
        if (srst_i)
            irq_reg <= '0;
        else begin
            irq_reg.tx_holding_free <= load_w
                | (cfg_i.port_enable & !en_q_reg);
            irq_reg.tx_all_empty <= act_reg & empty_w & !empty_q_reg;
            irq_reg.tx_overwrite <= wr_ok_w & thr_full_reg & !load_w;
            irq_reg.rx_holding_full <= push_w;
            irq_reg.rx_overrun <= overrun_w;
            irq_reg.command_detect <= detect_w;
        end
    end
    assign irq_o = irq_reg;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);

    overwrite_pulse_a: assert property (
        wr_ok_w && thr_full_reg && !load_w |=> irq_o.tx_overwrite)
        else $error("overwrite write not flagged");
    free_on_load_a: assert property (
        load_w |=> irq_o.tx_holding_free && tsr_v_reg && is_shift_w)
        else $error("load did not signal free holding register");
    msb_first_a: assert property (
        is_shift_w && tick_w && !half_reg
        |=> lvl_dat_reg == $past(tsr_reg[31]))
        else $error("launched bit is not the msb");
    gap_entry_a: assert property (
        bound_w && gap_w |=> is_gap_w && gcnt_reg == {cfg_i.gap_length, 1'b0})
        else $error("gap not entered with programmed length");
    proto_edges_a: assert property (
        is_shift_w && tick_w && !load_w && !tsr_swap_reg
        && !cfg_i.clock_invert && cfg_i.phase_select
        |-> ##2 bus_clock_pin_o == !$past(half_reg, 2))
        else $error("launch edge not rising");
    drain_hold_a: assert property (
        act_reg && !empty_w |=> act_reg)
        else $error("port dropped while transmitter busy");
    rx_load_a: assert property (
        push_w |=> irq_o.rx_holding_full && rx_valid_o)
        else $error("receive load not reported");
    rx_overrun_a: assert property (
        overrun_w |=> irq_o.rx_overrun && rx_valid_o && spare_v_reg)
        else $error("overrun not reported");
    rx_count_a: assert property (
        samp_w && !rx_last_w && !detect_w
        |=> rbit_reg == $past(rbit_reg) + 5'h01)
        else $error("receive bit count slipped");
    baud_reload_a: assert property (
        tick_w |=> brg_reg == $past(cfg_i.bit_rate_divisor))
        else $error("baud generator not preloaded");
endmodule // twp_port

// ==== verif/tb_top.sv ====
// self-checking bench for the two-wire serial port
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_compared++; \
    if ((got) !== (exp)) begin err_total++; \
    $display("unexpected %s exp %0h got %0h", nm, exp, got); end end
module tb_top;
    import twp_pkg::*;
    logic ref_clk_i = 1'b0;
    logic srst_i = 1'b1;
    twp_cfg_t cfg = '0;
    logic wr = 1'b0;
    logic swap = 1'b0;
    logic pswap = 1'b0;
    logic rdy = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic active, rvalid, co, coe, dout, doe, cl, dl;
    logic [31:0] rdata;
    twp_irq_t irq;
    int err_total = 0;
    int n_compared = 0;
    // pulse counts: 5 free, 4 empty, 3 overwrite, 2 full, 1 overrun, 0 cmd
    int cnt [6];
    int dur;
    int d0;
    always #10 ref_clk_i = ~ref_clk_i;
    // counted mid-cycle, so the bench never races the edge that sets a pulse
    always @(negedge ref_clk_i)
        for (int k = 0; k < 6; k++)
            if (irq[k] === 1'b1) cnt[k]++;
    twp_port twp_port_i (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
        .cfg_i(cfg), .port_active_o(active), .irq_o(irq), .tx_wr_i(wr),
        .tx_swap_i(swap), .tx_data_i(wdata), .rx_valid_o(rvalid),
        .rx_ready_i(rdy), .rx_data_o(rdata), .bus_clock_pin_i(cl),
        .bus_clock_pin_o(co), .bus_clock_pin_oe_n_o(coe),
        .bus_data_pin_i(dl), .bus_data_pin_o(dout),
        .bus_data_pin_oe_n_o(doe));
    twp_peer twp_peer_i (.clk_o_i(co), .clk_oe_n_i(coe), .dat_o_i(dout),
        .dat_oe_n_i(doe), .swap_i(pswap), .clk_line_o(cl), .dat_line_o(dl));
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // clear pulse counts and the peer's bit count on a rising clock edge
    task automatic zero();
        @(posedge ref_clk_i);
        foreach (cnt[k]) cnt[k] = 0;
        twp_peer_i.nbits = 0;
    endtask
    task automatic write(input logic [31:0] d, input logic s);
        @(posedge ref_clk_i);
        wr <= 1'b1;
        swap <= s;
        wdata <= d;
        @(posedge ref_clk_i);
        wr <= 1'b0;
    endtask
    task automatic wait_cnt(input int k, input int lim);
        dur = 0;
        while (cnt[k] == 0) begin
            cyc(1);
            dur++;
            if (dur > lim) begin
                err_total++;
                $display("unexpected timeout on pulse %0d", k);
                final_report();
            end
        end
    endtask
    task automatic pop();
        @(posedge ref_clk_i);
        rdy <= 1'b1;
        @(posedge ref_clk_i);
        rdy <= 1'b0;
        cyc(2);
    endtask
    initial begin
        cyc(8);
        srst_i <= 1'b0;
        cyc(1);
        `CHK("active", 1'b0, active)
        `CHK("irq", 6'h00, irq)
        `CHK("clk oe_n", 1'b1, coe)
        `CHK("rx valid", 1'b0, rvalid)
        zero();
        cfg.master <= 1'b1;
        cfg.phase_select <= 1'b1;
        cfg.port_enable <= 1'b1;
        cyc(4);
        `CHK("active", 1'b1, active)
        `CHK("free at enable", 1, cnt[5])
        `CHK("data oe_n", 1'b0, doe)
        $display("test reset done");
        zero();
        // third write lands while the second still waits in holding
        write(32'hdead_1111, 1'b0);
        write(32'h0000_2222, 1'b0);
        write(32'h0000_3333, 1'b0);
        wait_cnt(4, 2000);
        `CHK("overwrite", 1, cnt[3])
        `CHK("free count", 2, cnt[5])
        `CHK("bits", 32, twp_peer_i.nbits)
        `CHK("stream", 32'h1111_3333, twp_peer_i.cap)
        $display("test overwrite done");
        cfg.wide_group <= 1'b1;
        zero();
        write(32'h9abc_def1, 1'b0);
        wait_cnt(4, 2000);
        `CHK("wide bits", 32, twp_peer_i.nbits)
        `CHK("wide word", 32'h9abc_def1, twp_peer_i.cap)
        $display("test wide done");
        d0 = dur;
        cfg.halfword_gap_enable <= 1'b1;
        cfg.gap_length <= 8'h01;
        cfg.clock_invert <= 1'b1;
        cfg.phase_select <= 1'b0;
        // let the idle clock level settle before clearing the peer's bit count
        cyc(3);
        zero();
        write(32'h9abc_def1, 1'b0);
        wait_cnt(4, 2000);
        `CHK("inverted word", 32'h9abc_def1, twp_peer_i.cap)
        // one bit of gap after each halfword of the group, 2 ticks each
        `CHK("halfword gap", 4, dur - d0)
        $display("test halfword gap done");
        cfg.halfword_gap_enable <= 1'b0;
        cfg.clock_invert <= 1'b0;
        cfg.phase_select <= 1'b1;
        cfg.wide_group <= 1'b0;
        zero();
        write(32'h0000_00ff, 1'b0);
        wait_cnt(4, 2000);
        d0 = dur;
        cfg.byte_gap_enable <= 1'b1;
        cfg.gap_length <= 8'h02;
        zero();
        write(32'h0000_00ff, 1'b0);
        wait_cnt(4, 2000);
        // two byte ends, each 2 bits of 2 ticks at divisor 0
        `CHK("gap cycles", 8, dur - d0)
        $display("test gap done");
        cfg.byte_gap_enable <= 1'b0;
        cfg.gap_length <= 8'h00;
        pswap <= 1'b1;
        zero();
        write(32'h0000_5a0f, 1'b1);
        wait_cnt(4, 2000);
        `CHK("swapped word", 16'h5a0f, twp_peer_i.cap[15:0])
        pswap <= 1'b0;
        $display("test swap done");
        cfg.port_enable <= 1'b0;
        dur = 0;
        while (active === 1'b1) begin
            cyc(1);
            dur++;
            if (dur > 100) begin
                err_total++;
                $display("unexpected timeout on port shutdown");
                final_report();
            end
        end
        `CHK("active off", 1'b0, active)
        cyc(1);
        `CHK("clk released", 1'b1, coe)
        $display("test disable done");
        cfg.master <= 1'b0;
        cfg.port_enable <= 1'b1;
        cyc(4);
        zero();
        twp_peer_i.send(32'h0000_c3a5, 16);
        cyc(10);
        `CHK("rx full", 1, cnt[2])
        `CHK("rx valid", 1'b1, rvalid)
        `CHK("rx word", 32'h0000_c3a5, rdata)
        twp_peer_i.send(32'h0000_0f1e, 16);
        twp_peer_i.send(32'h0000_7788, 16);
        cyc(10);
        `CHK("overrun", 1, cnt[1])
        pop();
        `CHK("rx second", 32'h0000_0f1e, rdata)
        pop();
        `CHK("rx drained", 1'b0, rvalid)
        $display("test receive done");
        zero();
        twp_peer_i.cmd();
        cyc(10);
        `CHK("cmd detect", 1, cnt[0])
        $display("test command done");
        final_report();
    end
endmodule // tb_top

// ==== verif/twp_peer.sv ====
// far-side peripheral model: captures device frames, sends link frames
`timescale 1ns/1ps
module twp_peer (
    // device pin drives and line swap flag
    input wire logic clk_o_i,
    input wire logic clk_oe_n_i,
    input wire logic dat_o_i,
    input wire logic dat_oe_n_i,
    input wire logic swap_i,
    // resolved bus lines
    output logic clk_line_o,
    output logic dat_line_o
);
    logic pclk = 1'b0;
    logic pdat = 1'b0;
    logic [31:0] cap = 32'h0000_0000;
    int nbits = 0;
    wire logic bclk;
    wire logic bdat;
    assign clk_line_o = clk_oe_n_i ? pclk : clk_o_i;
    assign dat_line_o = dat_oe_n_i ? pdat : dat_o_i;
    // command words carry the clock on the data line
    assign bclk = swap_i ? dat_line_o : clk_line_o;
    assign bdat = swap_i ? clk_line_o : dat_line_o;
    always @(negedge bclk) begin
        if (!clk_oe_n_i) begin
            cap = {cap[30:0], bdat};
            nbits++;
        end
    end
    // link clock idles low between frames, 160 ns per bit
    task automatic send(input logic [31:0] w, input int n);
        #7;
        for (int k = n - 1; k >= 0; k--) begin
            pdat = w[k];
            pclk = 1'b1;
            #80;
            pclk = 1'b0;
            #80;
        end
        // frame over: data returns to its idle low level, so no stray rise
        pdat = 1'b0;
    endtask
    // two data rises with the clock held still
    task automatic cmd();
        repeat (2) begin
            pdat = 1'b0;
            #160;
            pdat = 1'b1;
            #160;
        end
        pdat = 1'b0;
    endtask
endmodule // twp_peer
